// ---- rtl/vipr_pkg.sv ----
// Package: register map, field layout and flag positions of the video info readback bank
package vipr_pkg;
  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_VIDEO_FORMAT_CODE     = 8'h84;
  localparam logic [7:0] ADDR_REPEAT_FACTOR         = 8'h85;
  localparam logic [7:0] ADDR_TOP_BAR_END_LOW       = 8'h86;
  localparam logic [7:0] ADDR_CHANGED_PACKETS_FIRST = 8'h87;
  localparam logic [7:0] ADDR_TOP_BAR_END_HIGH      = 8'h88;
  localparam logic [7:0] ADDR_BOTTOM_BAR_START_LOW  = 8'h89;
  localparam logic [7:0] ADDR_BOTTOM_BAR_START_HIGH = 8'h8A;
  localparam logic [7:0] ADDR_LEFT_BAR_END_LOW      = 8'h8B;
  localparam logic [7:0] ADDR_LEFT_BAR_END_HIGH     = 8'h8C;
  localparam logic [7:0] ADDR_RIGHT_BAR_START_LOW   = 8'h8D;
  localparam logic [7:0] ADDR_RIGHT_BAR_START_HIGH  = 8'h8E;
  localparam logic [7:0] ADDR_CHANGED_PACKETS_SECOND = 8'h8F;
  localparam logic [7:0] ADDR_CHANGED_PACKETS_AUDIO = 8'h97;
  localparam logic [7:0] ADDR_CHANGED_PACKETS_SPD   = 8'h9F;
  localparam logic [7:0] ADDR_IRQ_MASK              = 8'hF0;
  // ---------------------------------------------------------------------------
  // Field widths and reset values
  // ---------------------------------------------------------------------------
  localparam int          FORMAT_CODE_W   = 7;
  localparam int          REPEAT_W        = 4;
  localparam int          BAR_W           = 16;
  localparam int          FLAG_W          = 7;
  localparam logic [3:0]  REPEAT_MAX      = 4'h9;
  localparam logic [6:0]  FLAGS_RESET     = 7'h00;
  localparam logic [6:0]  MASK_RESET      = 7'h00;
  localparam logic [7:0]  UNMAPPED_DATA   = 8'h00;
  // ---------------------------------------------------------------------------
  // Changed-packet flag bit positions
  // ---------------------------------------------------------------------------
  localparam int FLAG_VIDEO_INFO   = 0;
  localparam int FLAG_AUDIO_INFO   = 1;
  localparam int FLAG_PRODUCT_INFO = 2;
  localparam int FLAG_MPEG_INFO    = 3;
  localparam int FLAG_CONTENT_PROT = 4;
  localparam int FLAG_TRACK_ID1    = 5;
  localparam int FLAG_TRACK_ID2    = 6;
endpackage

// ---- rtl/vipr_readback.sv ----
// Module: register bank of received video information packet fields, read-only except the interrupt mask
`timescale 1ns/1ns
// How it works
// [RULE1] Format code is a 7-bit read-only field in low bits of its register.
// [RULE2] Repeat factor is 4 bits; n means n+1 sends; 10 to 15 reserved.
// [RULE3] Top bar end line is 16 bits, low and high byte registers.
// [RULE4] Software reads top bar end of zero as no top bar.
// [RULE5] Bottom bar start line is 16 bits, low and high byte registers.
// [RULE6] Software reads bottom bar start beyond active lines as no bottom bar.
// [RULE7] Left bar end pixel is 16 bits, low and high byte registers.
// [RULE8] Software reads left bar end of zero as no left bar.
// [RULE9] Right bar start pixel is 16 bits, low and high byte registers.
// [RULE10] Software reads right bar start beyond line width as no right bar.
// [RULE11] A flag bit sets when its packet type content changes; idle reads zero.
// [RULE12] Reading any flag register clears all flags in every copy.
// [RULE13] All flag register copies return the same shared flag set.
// [RULE14] Flag bits: video, audio, product, mpeg, protection, track id 1, 2.
// [RULE15] Stored fields update on new packet; flag sets only when contents differ.
module vipr_readback (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // Register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  // Decoded video info packet from the link receiver
  input  wire logic        vid_pkt_valid_i,
  input  wire logic [6:0]  vid_format_code_i,
  input  wire logic [3:0]  vid_repeat_factor_i,
  input  wire logic [15:0] vid_top_bar_end_i,
  input  wire logic [15:0] vid_bottom_bar_start_i,
  input  wire logic [15:0] vid_left_bar_end_i,
  input  wire logic [15:0] vid_right_bar_start_i,
  // Change pulses from the other packet decoders, bits 1 to 6 used
  input  wire logic [6:0]  other_pkt_changed_i,
  output logic             irq_o,
  output logic             repeat_reserved_o
);

  // ---------------------------------------------------------------------------
  // Stored video packet fields
  // ---------------------------------------------------------------------------
  logic [vipr_pkg::FORMAT_CODE_W-1:0] video_format_code;
  logic [vipr_pkg::REPEAT_W-1:0]      repeat_factor;
  logic [vipr_pkg::BAR_W-1:0]         top_bar_end;
  logic [vipr_pkg::BAR_W-1:0]         bottom_bar_start;
  logic [vipr_pkg::BAR_W-1:0]         left_bar_end;
  logic [vipr_pkg::BAR_W-1:0]         right_bar_start;
  logic [vipr_pkg::FLAG_W-1:0]        changed_packet_flag;
  logic [vipr_pkg::FLAG_W-1:0]        irq_mask;
  logic                               vid_differs;
  logic                               flag_read;
  logic [vipr_pkg::FLAG_W-1:0]        flag_set;

  function automatic logic is_flag_addr(input logic [7:0] a);
    is_flag_addr = (a == vipr_pkg::ADDR_CHANGED_PACKETS_FIRST)
                || (a == vipr_pkg::ADDR_CHANGED_PACKETS_SECOND)
                || (a == vipr_pkg::ADDR_CHANGED_PACKETS_AUDIO)
                || (a == vipr_pkg::ADDR_CHANGED_PACKETS_SPD);
  endfunction

  // New packet differs from what is stored
  assign vid_differs = vid_pkt_valid_i && (
                         (vid_format_code_i      != video_format_code)
                      || (vid_repeat_factor_i    != repeat_factor)
                      || (vid_top_bar_end_i      != top_bar_end)
                      || (vid_bottom_bar_start_i != bottom_bar_start)
                      || (vid_left_bar_end_i     != left_bar_end)
                      || (vid_right_bar_start_i  != right_bar_start));   // see [RULE15]

  assign flag_read = rd_i && is_flag_addr(addr_i);                       // see [RULE12]

  always_comb begin
    flag_set                           = other_pkt_changed_i;
    flag_set[vipr_pkg::FLAG_VIDEO_INFO] = vid_differs;                   // see [RULE14]
  end

  // ---------------------------------------------------------------------------
  // Field capture
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      video_format_code <= '0;
      repeat_factor     <= '0;
      top_bar_end       <= '0;
      bottom_bar_start  <= '0;
      left_bar_end      <= '0;
      right_bar_start   <= '0;
    end else if (vid_pkt_valid_i) begin                                  // see [RULE15]
      video_format_code <= vid_format_code_i;                           // see [RULE1]
      repeat_factor     <= vid_repeat_factor_i;                         // see [RULE2]
      top_bar_end       <= vid_top_bar_end_i;                           // see [RULE3]
      bottom_bar_start  <= vid_bottom_bar_start_i;                      // see [RULE5]
      left_bar_end      <= vid_left_bar_end_i;                          // see [RULE7]
      right_bar_start   <= vid_right_bar_start_i;                       // see [RULE9]
    end
  end

  // ---------------------------------------------------------------------------
  // Shared changed-packet flags: set wins over the clear of a read
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      changed_packet_flag <= vipr_pkg::FLAGS_RESET;
    end else if (flag_read) begin
      changed_packet_flag <= flag_set;                                   // see [RULE12]
    end else begin
      changed_packet_flag <= changed_packet_flag | flag_set;             // see [RULE11]
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt mask, the only writable register
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      irq_mask <= vipr_pkg::MASK_RESET;
    end else if (wr_i && addr_i == vipr_pkg::ADDR_IRQ_MASK) begin
      irq_mask <= wdata_i[vipr_pkg::FLAG_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      irq_o             <= 1'b0;
      repeat_reserved_o <= 1'b0;
    end else begin
      irq_o             <= |(changed_packet_flag & irq_mask);
      repeat_reserved_o <= repeat_factor > vipr_pkg::REPEAT_MAX;         // see [RULE2]
    end
  end

  // ---------------------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      if (is_flag_addr(addr_i)) begin
        rdata_o <= {1'b0, changed_packet_flag};                          // see [RULE13]
      end else begin
        unique case (addr_i)
          vipr_pkg::ADDR_VIDEO_FORMAT_CODE:     rdata_o <= {1'b0, video_format_code};  // see [RULE1]
          vipr_pkg::ADDR_REPEAT_FACTOR:         rdata_o <= {4'h0, repeat_factor};      // see [RULE2]
          vipr_pkg::ADDR_TOP_BAR_END_LOW:       rdata_o <= top_bar_end[7:0];           // see [RULE3]
          vipr_pkg::ADDR_TOP_BAR_END_HIGH:      rdata_o <= top_bar_end[15:8];          // see [RULE3]
          vipr_pkg::ADDR_BOTTOM_BAR_START_LOW:  rdata_o <= bottom_bar_start[7:0];      // see [RULE5]
          vipr_pkg::ADDR_BOTTOM_BAR_START_HIGH: rdata_o <= bottom_bar_start[15:8];     // see [RULE5]
          vipr_pkg::ADDR_LEFT_BAR_END_LOW:      rdata_o <= left_bar_end[7:0];          // see [RULE7]
          vipr_pkg::ADDR_LEFT_BAR_END_HIGH:     rdata_o <= left_bar_end[15:8];         // see [RULE7]
          vipr_pkg::ADDR_RIGHT_BAR_START_LOW:   rdata_o <= right_bar_start[7:0];       // see [RULE9]
          vipr_pkg::ADDR_RIGHT_BAR_START_HIGH:  rdata_o <= right_bar_start[15:8];      // see [RULE9]
          vipr_pkg::ADDR_IRQ_MASK:              rdata_o <= {1'b0, irq_mask};
          default:                              rdata_o <= vipr_pkg::UNMAPPED_DATA;
        endcase
      end
    end
  end

endmodule

// ---- verification/video_info_packet_readback_tb.sv ----
// Testbench: register reads of the video info readback bank against a source model
`timescale 1ns/1ns
module video_info_packet_readback_tb;
  logic        ref_clk_i, reset_i, wr_i, rd_i, pend, vld, irq_o, rsv;
  logic [7:0]  addr_i, wdata_i, rdata_o, nexp, pexp;
  logic [74:0] fld;
  logic [6:0]  oth;
  int          num_errors = 0, n_checks = 0, i;
  logic [7:0]  fa [4] = '{8'h87, 8'h8F, 8'h97, 8'h9F};
  logic [7:0]  ra [10] = '{8'h84, 8'h85, 8'h86, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E};
  logic [7:0]  re [10] = '{8'h5A, 8'h09, 8'h34, 8'h12, 8'h38, 8'h04, 8'hF0, 8'h00, 8'h90, 8'h06};
  // Bars present: nonzero top and left ends, bottom and right starts inside the picture
  localparam logic [74:0] PKT = {7'h5A, 4'h9, 16'h1234, 16'h0438, 16'h00F0, 16'h0690};
  vipr_src_model i_src (.ref_clk_i, .vld_o(vld), .fields_o(fld), .changed_o(oth));
  vipr_readback i_dut (.ref_clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .vid_pkt_valid_i(vld),
    .vid_format_code_i(fld[74:68]), .vid_repeat_factor_i(fld[67:64]), .vid_top_bar_end_i(fld[63:48]),
    .vid_bottom_bar_start_i(fld[47:32]), .vid_left_bar_end_i(fld[31:16]), .vid_right_bar_start_i(fld[15:0]),
    .other_pkt_changed_i(oth), .irq_o, .repeat_reserved_o(rsv));
  task check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    wr_i <= 1'b0; rd_i <= 1'b1; addr_i <= a; nexp <= e;
    @(posedge ref_clk_i);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    rd_i <= 1'b0; wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
    @(posedge ref_clk_i);
  endtask
  task idle(input int n);
    rd_i <= 1'b0; wr_i <= 1'b0;
    repeat (n) @(posedge ref_clk_i);
  endtask
  task pins(input logic ie, input logic re_e);
    @(negedge ref_clk_i);
    check({6'h0, irq_o, rsv}, {6'h0, ie, re_e});
    @(posedge ref_clk_i);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Read data are compared in the cycle after the strobe
  always @(posedge ref_clk_i) begin
    if (pend) check(rdata_o, pexp);
    pend <= rd_i; pexp <= nexp;
  end
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    num_errors++;
    report_and_stop;
  end
  initial begin
    reset_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0; addr_i = 8'h00; wdata_i = 8'h00; pend = 1'b0; nexp = 8'h00;
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    rd(8'h84, 8'h00); rd(8'h87, 8'h00); rd(8'hF0, 8'h00); idle(2); pins(1'b0, 1'b0);
    $display("reset test done");
    wr(8'hF0, 8'h7F); idle(1); i_src.send(PKT);
    for (i = 0; i < 10; i++) rd(ra[i], re[i]);
    idle(1); pins(1'b1, 1'b0);
    rd(8'h87, 8'h01); rd(8'h8F, 8'h00); rd(8'h97, 8'h00); rd(8'h9F, 8'h00);
    idle(2); pins(1'b0, 1'b0); i_src.send(PKT); rd(8'h87, 8'h00);
    $display("field and flag test done");
    for (i = 0; i < 7; i++) begin
      idle(1); i_src.pulse(7'h01 << i); rd(fa[i % 4], (i == 0) ? 8'h00 : (8'h01 << i));
    end
    idle(1); i_src.send({7'h5A, 4'hA, PKT[63:0]}); rd(8'h85, 8'h0A); idle(2); pins(1'b1, 1'b1);
    wr(8'hF0, 8'h00); rd(8'hF0, 8'h00); idle(2); pins(1'b0, 1'b1); wr(8'hF0, 8'h01); idle(2); pins(1'b1, 1'b1);
    rd(8'h8F, 8'h01); idle(2); pins(1'b0, 1'b1);
    wr(8'h84, 8'hFF); rd(8'h84, 8'h5A); rd(8'h00, 8'h00); idle(2);
    $display("event and access test done");
    report_and_stop;
  end
endmodule
bind vipr_readback vipr_readback_sva i_sva (.ref_clk_i, .reset_i, .addr_i, .rd_i, .rdata_o, .vid_pkt_valid_i,
  .vid_format_code_i, .vid_repeat_factor_i, .other_pkt_changed_i, .irq_o, .repeat_reserved_o);

// ---- verification/vipr_readback_sva.sv ----
// Checker: port-level properties of the video info readback bank
`timescale 1ns/1ns
module vipr_readback_sva (
  input wire logic       ref_clk_i,
  input wire logic       reset_i,
  input wire logic [7:0] addr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       vid_pkt_valid_i,
  input wire logic [6:0] vid_format_code_i,
  input wire logic [3:0] vid_repeat_factor_i,
  input wire logic [6:0] other_pkt_changed_i,
  input wire logic       irq_o,
  input wire logic       repeat_reserved_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_quiet; !vid_pkt_valid_i && other_pkt_changed_i == 7'h00; endsequence
  sequence s_rd_flag; s_quiet ##0 (rd_i && addr_i inside {8'h87, 8'h8F, 8'h97, 8'h9F}); endsequence
  sequence s_pkt_rd(a); vid_pkt_valid_i ##1 (rd_i && addr_i == a && !vid_pkt_valid_i); endsequence
  a_reset_clears_out: assert property (disable iff (1'b0) reset_i |=> rdata_o == 8'h00 && !irq_o)
    else $error("outputs not cleared by reset");
  a_format_code_rd: assert property (s_pkt_rd(8'h84) |=> rdata_o == {1'b0, $past(vid_format_code_i, 2)})
    else $error("format code read wrong");
  a_repeat_rd: assert property (s_pkt_rd(8'h85) |=> rdata_o == {4'h0, $past(vid_repeat_factor_i, 2)})
    else $error("repeat factor read wrong");
  a_repeat_reserved: assert property (vid_pkt_valid_i ##1 !vid_pkt_valid_i |=>
    repeat_reserved_o == ($past(vid_repeat_factor_i, 2) > 4'h9)) else $error("reserved repeat flag wrong");
  a_rdata_holds: assert property (!rd_i |=> $stable(rdata_o)) else $error("read data moved without read");
  a_unmapped_zero: assert property (rd_i && addr_i == 8'h00 |=> rdata_o == 8'h00) else $error("unmapped read not zero");
  a_flag_read_clears: assert property (s_rd_flag ##1 s_rd_flag |=> rdata_o == 8'h00)
    else $error("flags not cleared by read");
  a_other_flag_set: assert property ((other_pkt_changed_i == 7'h02 && !vid_pkt_valid_i) ##1 s_rd_flag
    |=> rdata_o[1] && !rdata_o[7]) else $error("audio change flag missing");
  a_irq_after_clear: assert property (s_rd_flag ##1 s_quiet |=> !irq_o) else $error("irq stays after flag clear");
endmodule

// ---- verification/vipr_src_model.sv ----
// Model: video source giving decoded packet fields and change pulses
`timescale 1ns/1ns
module vipr_src_model (
  input  wire logic   ref_clk_i,
  output logic        vld_o,
  output logic [74:0] fields_o,
  output logic [6:0]  changed_o
);
  initial begin
    vld_o = 1'b0;
    fields_o = 75'h0;
    changed_o = 7'h00;
  end
  task send(input logic [74:0] f);
    vld_o <= 1'b1;
    fields_o <= f;
    @(posedge ref_clk_i);
    vld_o <= 1'b0;
  endtask
  task pulse(input logic [6:0] b);
    changed_o <= b;
    @(posedge ref_clk_i);
    changed_o <= 7'h00;
  endtask
endmodule
